// >>> rtcal_chk_if.sv
interface rtcal_chk_if;
  logic [31:0] wdata;
  logic        hr12;
  logic [3:0]  ok;
  modport regs (output wdata, output hr12, input ok);
  modport chk (input wdata, input hr12, output ok);
endinterface : rtcal_chk_if

// >>> rtcal_entry_check.sv
module rtcal_entry_check (
  rtcal_chk_if.chk bus
);
  logic [7:0] s, m, h, ce, y, mo, d, am, ad;
  logic [2:0] wd;
  logic       pm, hour_ok;

  always_comb begin
    s  = {1'b0, bus.wdata[rtcal_pkg::SEC_LSB +: 7]};
    m  = {1'b0, bus.wdata[rtcal_pkg::MIN_LSB +: 7]};
    h  = {2'b0, bus.wdata[rtcal_pkg::HOUR_LSB +: 6]};
    pm = bus.wdata[rtcal_pkg::HALF_DAY_BIT];
    ce = {1'b0, bus.wdata[rtcal_pkg::HUNDRED_YEARS_FIELD_LSB +: 7]};
    y  = bus.wdata[rtcal_pkg::YEAR_LSB +: 8];
    mo = {3'b0, bus.wdata[rtcal_pkg::MONTH_LSB +: 5]};
    wd = bus.wdata[rtcal_pkg::WDAY_LSB +: 3];
    d  = {2'b0, bus.wdata[rtcal_pkg::DATE_LSB +: 6]};
    am = {3'b0, bus.wdata[rtcal_pkg::MONTH_LSB +: 5]};
    ad = {2'b0, bus.wdata[rtcal_pkg::DATE_LSB +: 6]};
    // Half-day flag must stay clear in 24-hour operation
    hour_ok = rtcal_pkg::bcd_ok(h) && (bus.hr12 ? (h >= rtcal_pkg::BCD_01 && h <= rtcal_pkg::BCD_12)
                                                : (h <= rtcal_pkg::BCD_23 && !pm));
    bus.ok[0] = rtcal_pkg::bcd_ok(s) && s <= rtcal_pkg::BCD_59
             && rtcal_pkg::bcd_ok(m) && m <= rtcal_pkg::BCD_59 && hour_ok;
    bus.ok[1] = (ce == rtcal_pkg::BCD_19 || ce == rtcal_pkg::BCD_20)
             && rtcal_pkg::bcd_ok(y)
             && rtcal_pkg::bcd_ok(mo) && mo >= rtcal_pkg::BCD_01 && mo <= rtcal_pkg::BCD_12
             && wd >= rtcal_pkg::WDAY_MIN && wd <= rtcal_pkg::WDAY_MAX
             && rtcal_pkg::bcd_ok(d) && d >= rtcal_pkg::BCD_01 && d <= rtcal_pkg::month_days(mo, y);
    bus.ok[2] = bus.ok[0];
    bus.ok[3] = rtcal_pkg::bcd_ok(am) && am >= rtcal_pkg::BCD_01 && am <= rtcal_pkg::BCD_12
             && rtcal_pkg::bcd_ok(ad) && ad >= rtcal_pkg::BCD_01 && ad <= rtcal_pkg::BCD_31;
  end
endmodule : rtcal_entry_check

// >>> rtcal_pkg.sv
package rtcal_pkg;
  // =====================================================================
  // Register map, byte addresses
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_MODE = 6'h04;
  localparam logic [5:0] OFS_TIME = 6'h08;
  localparam logic [5:0] OFS_CAL  = 6'h0c;
  localparam logic [5:0] OFS_TALR = 6'h10;
  localparam logic [5:0] OFS_CALR = 6'h14;
  localparam logic [5:0] OFS_SR   = 6'h18;
  localparam logic [5:0] OFS_SCCR = 6'h1c;
  localparam logic [5:0] OFS_IER  = 6'h20;
  localparam logic [5:0] OFS_IDR  = 6'h24;
  localparam logic [5:0] OFS_IMR  = 6'h28;
  localparam logic [5:0] OFS_VER  = 6'h2c;
  // =====================================================================
  // Field positions and implemented-bit masks
  localparam int SEC_LSB = 0, MIN_LSB = 8, HOUR_LSB = 16, HALF_DAY_BIT = 22;
  localparam int HUNDRED_YEARS_FIELD_LSB = 0, YEAR_LSB = 8, MONTH_LSB = 16, WDAY_LSB = 21, DATE_LSB = 24;
  localparam int S_EN_BIT = 7, M_EN_BIT = 15, HOUR_EN_BIT = 23, MONTH_EN_BIT = 23, DATE_EN_BIT = 31;
  localparam int TSEL_LSB = 8, DSEL_LSB = 16;
  localparam int SR_ACK = 0, SR_ALR = 1, SR_SEC = 2, SR_TIM = 3, SR_CAL = 4, SR_W = 5;
  localparam logic [31:0] TIME_MASK = 32'h007f7f7f;
  localparam logic [31:0] CAL_MASK  = 32'h3fffff7f;
  localparam logic [31:0] TALR_MASK = 32'h00ffffff;
  localparam logic [31:0] CALR_MASK = 32'hbf9f0000;
  localparam logic [31:0] CTRL_MASK = 32'h00030303;
  // =====================================================================
  // Reset values
  localparam logic [31:0] TIME_RST = 32'h00000000;
  localparam logic [31:0] CAL_RST  = 32'h01819819;
  localparam logic [31:0] TALR_RST = 32'h00000000;
  localparam logic [31:0] CALR_RST = 32'h01010000;
  // =====================================================================
  // BCD limits
  localparam logic [7:0] BCD_00 = 8'h00, BCD_01 = 8'h01, BCD_11 = 8'h11, BCD_12 = 8'h12;
  localparam logic [7:0] BCD_19 = 8'h19, BCD_20 = 8'h20, BCD_23 = 8'h23, BCD_59 = 8'h59;
  localparam logic [7:0] BCD_99 = 8'h99, BCD_28 = 8'h28, BCD_29 = 8'h29, BCD_30 = 8'h30;
  localparam logic [7:0] BCD_31 = 8'h31;
  localparam logic [2:0] WDAY_MIN = 3'h1, WDAY_MAX = 3'h7, WEEK_START = 3'h1;
  // =====================================================================
  // Timing
  localparam longint SEC_PERIOD_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 10;
  localparam int unsigned SEC_CYCLES = int'(SEC_PERIOD_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {TEV_MIN = 2'h0, TEV_HOUR = 2'h1, TEV_MIDNIGHT = 2'h2, TEV_NOON = 2'h3} rtcal_tev_t;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic bcd_ok(input logic [7:0] v);
    return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9);
  endfunction : bcd_ok

  // Every year divisible by four is leap, good up to the end of the century range
  function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02:                      return leap ? BCD_29 : BCD_28;
      8'h04, 8'h06, 8'h09, 8'h11: return BCD_30;
      default:                    return BCD_31;
    endcase
  endfunction : month_days
endpackage : rtcal_pkg

// >>> rtcal_regs.sv
// Behaviour
// - Seconds and minutes are BCD, 00 to 59.
// - Every BCD field keeps units in the low nibble, tens above.
// - Hour takes 01-12 in twelve-hour mode, 00-23 in twenty-four-hour mode.
// - Bit 22 is the half-day flag in twelve-hour mode, 1 means afternoon.
// - Unused bits of time and calendar read zero.
// - Century takes only 19 or 20; counting past year 99 of century 20 still steps it to 21.
// - Year is two BCD digits, 00 to 99.
// - Month is BCD 01 to 12.
// - Weekday takes 1 to 7 and never affects date counting.
// - Day of month is BCD 01 to 31.
// - Time alarm compares second, minute, hour with per-field enables at 7, 15, 23.
// - Calendar alarm compares month (enable 23) and date (enable 31).
// - Status bit 0 is one only while time or calendar may be written.
// - Status bit 1 sets when all enabled alarm fields match.
// - Status bit 2 sets every second tick and stays until cleared.
// - Status bit 3 latches the selected time event until cleared.
// - Status bit 4 latches the selected calendar event until cleared.
// - Writing one to the clear command clears that status flag.
// - Writing one to the enable command enables that interrupt.
// - Writing one to the disable command disables that interrupt.
// - Time event select: minute, hour, midnight, noon.
// - Calendar event select: Monday midnight, first of month, first of January.
// - Update request stops the counting and raises the acknowledge flag.
// - A rejected time, calendar or alarm write is not loaded and flags invalid.
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
module rtcal_regs #(
  parameter int unsigned SEC_CYCLES = rtcal_pkg::SEC_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic [5:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  output logic             irq_out
);
  // =====================================================================
  // State
  typedef struct packed {
    logic                     ack;
    logic [31:0]              rdata;
    logic [31:0]              tim;
    logic [31:0]              cal;
    logic [31:0]              talr;
    logic [31:0]              calr;
    logic [1:0]               upd;
    logic [1:0]               tsel;
    logic [1:0]               dsel;
    logic                     hr12;
    logic [rtcal_pkg::SR_W-1:0] sr;
    logic [rtcal_pkg::SR_W-1:0] imr;
    logic [3:0]               ver;
    logic                     tick_d;
  } rtcal_state_t;

  rtcal_state_t r, n;
  logic         tick, req, acc, wr, amatch;
  rtcal_chk_if  chk ();

  rtcal_sec_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .tick_out   (tick)
  );

  rtcal_entry_check u_chk (
    .bus (chk.chk)
  );

  function automatic logic [31:0] rd_sel(input logic [5:0] a, input rtcal_state_t s);
    case (a)
      rtcal_pkg::OFS_CTRL: return {14'h0, s.dsel, 6'h0, s.tsel, 6'h0, s.upd};
      rtcal_pkg::OFS_MODE: return {31'h0, s.hr12};
      rtcal_pkg::OFS_TIME: return s.tim & rtcal_pkg::TIME_MASK;
      rtcal_pkg::OFS_CAL:  return s.cal & rtcal_pkg::CAL_MASK;
      rtcal_pkg::OFS_TALR: return s.talr;
      rtcal_pkg::OFS_CALR: return s.calr;
      rtcal_pkg::OFS_SR:   return {27'h0, s.sr};
      rtcal_pkg::OFS_IMR:  return {27'h0, s.imr};
      rtcal_pkg::OFS_VER:  return {28'h0, s.ver};
      default:             return 32'h0;
    endcase
  endfunction : rd_sel

  // =====================================================================
  // Bus handshake: one wait cycle, data latched on the first
  assign req             = read_in | write_in;
  assign waitrequest_out = req & ~r.ack;
  assign acc             = req & r.ack;
  assign wr              = write_in & acc;
  assign readdata_out    = r.rdata;
  assign irq_out         = |(r.sr & r.imr);

  logic [31:0] bem;
  always_comb begin
    bem = {{8{byteenable_in[3]}}, {8{byteenable_in[2]}}, {8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
    chk.wdata = (rd_sel(address_in, r) & ~bem) | (writedata_in & bem);
    chk.hr12  = r.hr12;
  end

  // =====================================================================
  // Alarm compare
  always_comb begin
    logic any_en;
    any_en = r.talr[rtcal_pkg::S_EN_BIT] | r.talr[rtcal_pkg::M_EN_BIT] | r.talr[rtcal_pkg::HOUR_EN_BIT]
           | r.calr[rtcal_pkg::MONTH_EN_BIT] | r.calr[rtcal_pkg::DATE_EN_BIT];
    amatch = any_en
      && (!r.talr[rtcal_pkg::S_EN_BIT] || r.talr[rtcal_pkg::SEC_LSB +: 7] == r.tim[rtcal_pkg::SEC_LSB +: 7])
      && (!r.talr[rtcal_pkg::M_EN_BIT] || r.talr[rtcal_pkg::MIN_LSB +: 7] == r.tim[rtcal_pkg::MIN_LSB +: 7])
      && (!r.talr[rtcal_pkg::HOUR_EN_BIT] || r.talr[rtcal_pkg::HOUR_LSB +: 7] == r.tim[rtcal_pkg::HOUR_LSB +: 7])
      && (!r.calr[rtcal_pkg::MONTH_EN_BIT]
          || r.calr[rtcal_pkg::MONTH_LSB +: 5] == r.cal[rtcal_pkg::MONTH_LSB +: 5])
      && (!r.calr[rtcal_pkg::DATE_EN_BIT] || r.calr[rtcal_pkg::DATE_LSB +: 6] == r.cal[rtcal_pkg::DATE_LSB +: 6]);
  end

  // =====================================================================
  // Counting, events, registers
  logic [7:0] sec, mnt, hr, cen, yr, mon, dat, n_dat, n_hr;
  logic [7:0] n_sec, n_mnt, n_mon, n_cen;
  logic [2:0] wday, n_wday;
  logic       pm, sec_w, min_w, day_w, noon_w, dat_w, mon_w, run_t, run_c, ev_t, ev_c, t_ok, c_ok;
  logic [rtcal_pkg::SR_W-1:0] clr, set;

  always_comb begin
    n        = r;
    n.ack    = req & ~r.ack;
    n.tick_d = tick;
    if (req && !r.ack) begin
      n.rdata = rd_sel(address_in, r);
    end
    sec  = {1'b0, r.tim[rtcal_pkg::SEC_LSB +: 7]};
    mnt  = {1'b0, r.tim[rtcal_pkg::MIN_LSB +: 7]};
    hr   = {2'b0, r.tim[rtcal_pkg::HOUR_LSB +: 6]};
    pm   = r.tim[rtcal_pkg::HALF_DAY_BIT];
    cen  = {1'b0, r.cal[rtcal_pkg::HUNDRED_YEARS_FIELD_LSB +: 7]};
    yr   = r.cal[rtcal_pkg::YEAR_LSB +: 8];
    mon  = {3'b0, r.cal[rtcal_pkg::MONTH_LSB +: 5]};
    wday = r.cal[rtcal_pkg::WDAY_LSB +: 3];
    dat  = {2'b0, r.cal[rtcal_pkg::DATE_LSB +: 6]};
    n_sec = rtcal_pkg::bcd_inc(sec);
    n_mnt = rtcal_pkg::bcd_inc(mnt);
    n_mon = rtcal_pkg::bcd_inc(mon);
    n_cen = rtcal_pkg::bcd_inc(cen);
    // Writes are only allowed once the stop is acknowledged
    t_ok  = r.upd[0] & r.sr[rtcal_pkg::SR_ACK];
    c_ok  = r.upd[1] & r.sr[rtcal_pkg::SR_ACK];
    run_t = tick & ~t_ok;
    run_c = ~c_ok;
    sec_w = sec == rtcal_pkg::BCD_59;
    min_w = sec_w && mnt == rtcal_pkg::BCD_59;
    if (r.hr12) begin
      n_hr   = (hr == rtcal_pkg::BCD_12) ? rtcal_pkg::BCD_01 : rtcal_pkg::bcd_inc(hr);
      day_w  = min_w && hr == rtcal_pkg::BCD_11 && pm;
      noon_w = min_w && hr == rtcal_pkg::BCD_11 && !pm;
    end else begin
      n_hr   = (hr == rtcal_pkg::BCD_23) ? rtcal_pkg::BCD_00 : rtcal_pkg::bcd_inc(hr);
      day_w  = min_w && hr == rtcal_pkg::BCD_23;
      noon_w = min_w && hr == rtcal_pkg::BCD_11;
    end
    // Weekday wraps on its own and never feeds the date chain
    n_wday = (wday == rtcal_pkg::WDAY_MAX) ? rtcal_pkg::WDAY_MIN : wday + 3'h1;
    dat_w  = dat == rtcal_pkg::month_days(mon, yr);
    n_dat  = dat_w ? rtcal_pkg::BCD_01 : rtcal_pkg::bcd_inc(dat);
    mon_w  = dat_w && mon == rtcal_pkg::BCD_12;
    if (run_t) begin
      n.tim[rtcal_pkg::SEC_LSB +: 7] = sec_w ? 7'h0 : n_sec[6:0];
      if (sec_w) begin
        n.tim[rtcal_pkg::MIN_LSB +: 7] = min_w ? 7'h0 : n_mnt[6:0];
      end
      if (min_w) begin
        n.tim[rtcal_pkg::HOUR_LSB +: 6] = n_hr[5:0];
        if (r.hr12 && hr == rtcal_pkg::BCD_11) begin
          n.tim[rtcal_pkg::HALF_DAY_BIT] = ~pm;
        end
      end
      if (day_w && run_c) begin
        n.cal[rtcal_pkg::WDAY_LSB +: 3] = n_wday;
        n.cal[rtcal_pkg::DATE_LSB +: 6] = n_dat[5:0];
        if (dat_w) begin
          n.cal[rtcal_pkg::MONTH_LSB +: 5] = mon_w ? rtcal_pkg::BCD_01[4:0] : n_mon[4:0];
        end
        if (mon_w) begin
          n.cal[rtcal_pkg::YEAR_LSB +: 8] = (yr == rtcal_pkg::BCD_99) ? rtcal_pkg::BCD_00 : rtcal_pkg::bcd_inc(yr);
          if (yr == rtcal_pkg::BCD_99) begin
            n.cal[rtcal_pkg::HUNDRED_YEARS_FIELD_LSB +: 7] = n_cen[6:0];
          end
        end
      end
    end
    unique case (rtcal_pkg::rtcal_tev_t'(r.tsel))
      rtcal_pkg::TEV_MIN:      ev_t = sec_w;
      rtcal_pkg::TEV_HOUR:     ev_t = min_w;
      rtcal_pkg::TEV_MIDNIGHT: ev_t = day_w;
      rtcal_pkg::TEV_NOON:     ev_t = noon_w;
    endcase
    ev_t = ev_t & run_t;
    // Codes 2 and 3 both mean new year
    ev_c = run_t && day_w && run_c && ((r.dsel == 2'h0) ? (n_wday == rtcal_pkg::WEEK_START)
                                     : (r.dsel == 2'h1) ? dat_w : mon_w);
    // Set wins over a clear in the same cycle
    clr = '0;
    set = '0;
    if (wr && address_in == rtcal_pkg::OFS_SCCR) begin
      clr = writedata_in[rtcal_pkg::SR_W-1:0] & bem[rtcal_pkg::SR_W-1:0];
    end
    if (r.upd == 2'h0) begin
      clr[rtcal_pkg::SR_ACK] = 1'b1;
    end
    set[rtcal_pkg::SR_ACK] = tick & (|r.upd);
    set[rtcal_pkg::SR_ALR] = r.tick_d & amatch;
    set[rtcal_pkg::SR_SEC] = tick;
    set[rtcal_pkg::SR_TIM] = ev_t;
    set[rtcal_pkg::SR_CAL] = ev_c;
    n.sr = (r.sr & ~clr) | set;
    if (wr) begin
      unique case (address_in)
        rtcal_pkg::OFS_CTRL: begin
          n.upd  = chk.wdata[1:0];
          n.tsel = chk.wdata[rtcal_pkg::TSEL_LSB +: 2];
          n.dsel = chk.wdata[rtcal_pkg::DSEL_LSB +: 2];
        end
        rtcal_pkg::OFS_MODE: n.hr12 = chk.wdata[0];
        rtcal_pkg::OFS_TIME: if (t_ok) begin
          n.ver[0] = ~chk.ok[0];
          if (chk.ok[0]) n.tim = chk.wdata & rtcal_pkg::TIME_MASK;
        end
        rtcal_pkg::OFS_CAL: if (c_ok) begin
          n.ver[1] = ~chk.ok[1];
          if (chk.ok[1]) n.cal = chk.wdata & rtcal_pkg::CAL_MASK;
        end
        rtcal_pkg::OFS_TALR: begin
          n.ver[2] = ~chk.ok[2];
          if (chk.ok[2]) n.talr = chk.wdata & rtcal_pkg::TALR_MASK;
        end
        rtcal_pkg::OFS_CALR: begin
          n.ver[3] = ~chk.ok[3];
          if (chk.ok[3]) n.calr = chk.wdata & rtcal_pkg::CALR_MASK;
        end
        rtcal_pkg::OFS_IER: n.imr = r.imr | (writedata_in[rtcal_pkg::SR_W-1:0] & bem[rtcal_pkg::SR_W-1:0]);
        rtcal_pkg::OFS_IDR: n.imr = r.imr & ~(writedata_in[rtcal_pkg::SR_W-1:0] & bem[rtcal_pkg::SR_W-1:0]);
        default: ;
      endcase
    end
  end

  // Time base is made in this domain, so status flags never cross clocks
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r      <= '0;
      r.tim  <= rtcal_pkg::TIME_RST;
      r.cal  <= rtcal_pkg::CAL_RST;
      r.talr <= rtcal_pkg::TALR_RST;
      r.calr <= rtcal_pkg::CALR_RST;
    end else begin
      r <= n;
    end
  end

  // =====================================================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  AST_SEC_MIN_RANGE: assert property (r.tim[6:0] <= 7'h59 && r.tim[14:8] <= 7'h59)
    else $error("seconds or minutes out of range");
  AST_HOUR_RANGE: assert property (r.hr12 |-> (r.tim[21:16] >= 6'h01 || r.tim == 32'h0) && r.tim[21:16] <= 6'h12)
    else $error("hour out of twelve-hour range");
  AST_UNUSED_ZERO: assert property ((r.tim & ~rtcal_pkg::TIME_MASK) == 32'h0 && (r.cal & ~rtcal_pkg::CAL_MASK) == 32'h0)
    else $error("unused time or calendar bits set");
  AST_HUNDRED_YEARS_FIELD_RANGE: assert property (r.cal[6:0] == 7'h19 || r.cal[6:0] == 7'h20)
    else $error("century out of range");
  AST_SEC_FLAG: assert property (tick |=> r.sr[rtcal_pkg::SR_SEC])
    else $error("second flag not set after tick");
  AST_ALARM_SET: assert property (r.tick_d && amatch |=> r.sr[rtcal_pkg::SR_ALR])
    else $error("alarm flag missed a match");
  AST_CLEAR: assert property (wr && address_in == rtcal_pkg::OFS_SCCR && writedata_in[2] && byteenable_in[0] && !tick
                              |=> !r.sr[rtcal_pkg::SR_SEC])
    else $error("second flag not cleared");
  AST_IER: assert property (wr && address_in == rtcal_pkg::OFS_IER && writedata_in[1] && byteenable_in[0]
                            |=> r.imr[1])
    else $error("alarm interrupt not enabled");
  AST_IDR: assert property (wr && address_in == rtcal_pkg::OFS_IDR && writedata_in[1] && byteenable_in[0]
                            |=> !r.imr[1])
    else $error("alarm interrupt not disabled");
  AST_IRQ: assert property (irq_out == |(r.sr & r.imr))
    else $error("interrupt output disagrees with flags");
  AST_ACK_DROP: assert property (r.upd == 2'h0 |=> !r.sr[rtcal_pkg::SR_ACK])
    else $error("acknowledge stands without request");
  AST_FROZEN: assert property (r.upd[0] && r.sr[rtcal_pkg::SR_ACK] && !wr ##1 r.upd[0] |-> $stable(r.tim))
    else $error("time counted while stopped");
  AST_REJECT: assert property (wr && address_in == rtcal_pkg::OFS_TALR && !chk.ok[2]
                               |=> r.ver[2] && $stable(r.talr))
    else $error("invalid alarm loaded");
  AST_WAIT_ONE: assert property (req && !r.ack |=> !waitrequest_out || !req)
    else $error("waitrequest longer than one cycle");

  COV_ALARM: cover property (r.tick_d && amatch);
  COV_DAY_WRAP: cover property (run_t && day_w);
  COV_UPDATE: cover property (r.sr[rtcal_pkg::SR_ACK] && wr && address_in == rtcal_pkg::OFS_TIME);
  COV_IRQ: cover property ($rose(irq_out));
endmodule : rtcal_regs

// >>> rtcal_regs_bench.sv
module rtcal_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================
  // Short second so the whole run stays brief
  localparam int unsigned SC = 20;
  logic        clk_sys_in    = 1'b0;
  logic        reset_n_in    = 1'b0;
  logic        read_in       = 1'b0;
  logic        write_in      = 1'b0;
  logic [5:0]  address_in    = 6'h00;
  logic [31:0] writedata_in  = 32'h0;
  logic [3:0]  byteenable_in = 4'hf;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic        irq_out;
  int          failures      = 0;
  int          n_checks      = 0;
  int          s;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] bad_cal[5]    = '{32'h29622421, 32'h29732420, 32'h32622420, 32'h29022420, 32'h29622a20};

  rtcal_regs #(.SEC_CYCLES(SC)) u_rtcal_regs (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(byteenable_in), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .irq_out(irq_out));

  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic end_sim;
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // =====================================================
  // Avalon master: hold until waitrequest seen low at an edge
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    read_in      <= rd;
    write_in     <= !rd;
    address_in   <= a;
    writedata_in <= d;
    do @(posedge clk_sys_in); while (waitrequest_out !== 1'b0);
    read_in  <= 1'b0;
    write_in <= 1'b0;
  endtask : bus

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b1, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask : wr

  task automatic chk_irq(input logic e);
    #1;
    n_checks++;
    if (irq_out !== e) begin
      failures++;
      $display("BAD irq_out exp %b got %b", e, irq_out);
    end
  endtask : chk_irq

  task automatic ticks(input int n);
    repeat (n * SC) @(posedge clk_sys_in);
  endtask : ticks

  // =====================================================
  // Monitor: read data taken at the rising edge where waitrequest is low
  always @(posedge clk_sys_in) begin
    if (read_in && waitrequest_out === 1'b0) begin
      n_checks++;
      if (exp_q.size() == 0) begin
        failures++;
        $display("BAD readdata exp none got %h", readdata_out);
      end else begin
        if ((readdata_out & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
          failures++;
          $display("BAD readdata exp %h got %h", exp_q[0], readdata_out);
        end
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  initial begin
    s = $urandom(54036);
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    rd(6'h08, 32'h00000000, 32'hffffffff);
    rd(6'h0c, 32'h01819819, 32'hffffffff);
    rd(6'h14, 32'h01010000, 32'hffffffff);
    rd(6'h18, 32'h00000000, 32'hffffffff);
    rd(6'h1c, 32'h00000000, 32'hffffffff);
    rd(6'h30, 32'h00000000, 32'hffffffff);
    wr(6'h00, 32'h00000003);
    ticks(2);
    rd(6'h18, 32'h00000001, 32'h00000001);
    wr(6'h08, 32'h00125959);
    rd(6'h08, 32'h00125959, 32'hffffffff);
    wr(6'h08, 32'h00006000);
    rd(6'h08, 32'h00125959, 32'hffffffff);
    wr(6'h08, 32'h00245959);
    rd(6'h08, 32'h00125959, 32'hffffffff);
    rd(6'h2c, 32'h00000001, 32'h00000001);
    wr(6'h0c, 32'h29622420);
    rd(6'h0c, 32'h29622420, 32'hffffffff);
    // Century, month, date, weekday and BCD digit out of range in turn
    foreach (bad_cal[i]) begin
      wr(6'h0c, bad_cal[i]);
      rd(6'h0c, 32'h29622420, 32'hffffffff);
    end
    // Dropping both requests clears the acknowledge and restarts counting
    wr(6'h00, 32'h00000100);
    rd(6'h18, 32'h00000000, 32'h00000001);
    ticks(1);
    rd(6'h08, 32'h00130000, 32'hffffff00);
    rd(6'h18, 32'h0000000c, 32'h0000000c);
    wr(6'h20, 32'h00000004);
    chk_irq(1'b1);
    wr(6'h24, 32'h00000004);
    chk_irq(1'b0);
    wr(6'h20, 32'h00000008);
    chk_irq(1'b1);
    wr(6'h1c, 32'h00000008);
    chk_irq(1'b0);
    rd(6'h18, 32'h00000000, 32'h00000008);
    s = $urandom_range(59, 2);
    wr(6'h10, {24'h0, 1'b1, 3'(s / 10), 4'(s % 10)});
    wr(6'h1c, 32'h00000002);
    ticks(62);
    rd(6'h18, 32'h00000002, 32'h00000002);
    end_sim();
  end

  initial begin
    #100000;
    failures++;
    end_sim();
  end
endmodule : rtcal_regs_bench

// >>> rtcal_sec_tick.sv
module rtcal_sec_tick #(
  parameter int unsigned SEC_CYCLES = rtcal_pkg::SEC_CYCLES
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  output logic      tick_out
);
  localparam int CW = $clog2(SEC_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SEC_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } rtcal_tick_t;

  rtcal_tick_t r, n;

  always_comb begin
    n      = r;
    n.tick = (r.cnt == LAST);
    n.cnt  = n.tick ? '0 : r.cnt + CW'(1);
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick_out = r.tick;
endmodule : rtcal_sec_tick
